// *** hdl/eewg_top.sv ***
// Data EEPROM access and write guard with AHB-Lite register slave
// Functional notes
// - Power-on reset clears the write-enable gate bit.
// - No write may start until the power-up delay timer has run out.
// - A write starts only with the gate set and the unlock sequence done.
// - Code protection does not block or scramble EEPROM reads and writes.
// - Data, address and control registers sit at indices 9Ah, 9Bh, 9Ch.
// - The unlock port at 9Dh stores nothing and reads as zero.
// - Data and address survive non-power-on resets; control start and gate bits reset low.
// - Read and write start bits are set-only and cleared by hardware.
// - A finished write clears write-start and sets the complete flag.
// - An external or watchdog reset mid-write sets the abort flag.
`timescale 1ns/1ps
module eewg_top
    import eewg_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_CNT = POWERUP_DELAY_TIMER_CYCLES,
    parameter int WR_CNT   = WRITE_CYCLES
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               external_reset_pin,
    input  wire logic               watchdog_timeout,
    input  wire logic               code_protect,
    output logic                    irq
);
    import eewg_pkg::*;

    // ============================================================
    // Pin synchronisers
    // ============================================================
    logic [1:0] ext_sync;
    logic [1:0] wdt_sync;
    logic [1:0] cp_sync;
    logic       soft_reset;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_sync <= 2'b00;
            wdt_sync <= 2'b00;
            cp_sync  <= 2'b00;
        end else begin
            ext_sync <= {ext_sync[0], external_reset_pin};
            wdt_sync <= {wdt_sync[0], watchdog_timeout};
            cp_sync  <= {cp_sync[0], code_protect};
        end
    end

    assign soft_reset = ext_sync[1] | wdt_sync[1];

    // ============================================================
    // AHB-Lite address phase capture
    // ============================================================
    logic               dp_write;
    logic               dp_read;
    logic [ADDR_W-1:0]  dp_addr;
    logic               dp_word;
    logic               ap_valid;

    assign ap_valid  = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= '0;
            dp_word  <= 1'b0;
        end else begin
            dp_write <= ap_valid & hwrite;
            dp_read  <= ap_valid & ~hwrite;
            dp_addr  <= haddr[ADDR_W+1:2];
            dp_word  <= (hsize == 3'b010) && (haddr[1:0] == 2'b00);
        end
    end

    logic wr_data;
    logic wr_addr;
    logic wr_ctrl;
    logic wr_unlock;
    logic wr_irq_clr;
    logic wr_irq_en;
    logic [7:0] wbyte;

    assign wbyte      = hwdata[7:0];
    assign wr_data    = dp_write && dp_word && dp_addr == ADDR_W'(DATA_IDX);
    assign wr_addr    = dp_write && dp_word && dp_addr == ADDR_W'(ADDR_IDX);
    assign wr_ctrl    = dp_write && dp_word && dp_addr == ADDR_W'(CTRL_IDX);
    assign wr_unlock  = dp_write && dp_word &&
                        dp_addr == ADDR_W'(UNLOCK_IDX);
    assign wr_irq_clr = dp_write && dp_word &&
                        dp_addr == ADDR_W'(IRQ_CLR_IDX);
    assign wr_irq_en  = dp_write && dp_word && dp_addr == ADDR_W'(IRQ_EN_IDX);

    // ============================================================
    // Power-up delay timer
    // ============================================================
    logic [23:0] powerup_delay_timer_count;
    logic        powerup_delay_timer_done;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            powerup_delay_timer_count <= 24'h00_0000;
            powerup_delay_timer_done  <= 1'b0;
        end else if (!powerup_delay_timer_done) begin
            if (powerup_delay_timer_count == 24'(POWERUP_DELAY_TIMER_CNT - 1)) begin
                powerup_delay_timer_done <= 1'b1;
            end else begin
                powerup_delay_timer_count <= powerup_delay_timer_count + 24'h00_0001;
            end
        end
    end

    // ============================================================
    // Control register and unlock sequence
    // ============================================================
    logic [7:0]  eeprom_data_reg;
    logic [7:0]  eeprom_address_reg;
    logic        read_start;
    logic        write_start;
    logic        write_enable_gate;
    logic        write_abort_flag;
    eewg_unl_t   unl_state;
    logic [4:0]  unl_timer;
    logic        arr_busy;
    logic        arr_done;
    logic        arr_start;
    logic [7:0]  arr_rdata;
    logic        start_ok;

    // gate, timer and unlock all needed
    assign start_ok  = wr_ctrl && wbyte[CTRL_WR_BIT] && write_enable_gate &&
                       powerup_delay_timer_done && unl_state == UNL_KEY2 && !arr_busy &&
                       !soft_reset;
    assign arr_start = start_ok;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unl_state <= UNL_IDLE;
            unl_timer <= 5'h00;
        end else if (soft_reset) begin
            unl_state <= UNL_IDLE;
        end else if (dp_write) begin
            unl_timer <= 5'h00;
            case (unl_state)
                UNL_IDLE: begin
                    unl_state <= (wr_unlock && wbyte == UNLOCK_KEY1)
                                 ? UNL_KEY1 : UNL_IDLE;
                end
                UNL_KEY1: begin
                    unl_state <= (wr_unlock && wbyte == UNLOCK_KEY2)
                                 ? UNL_KEY2 : UNL_IDLE;
                end
                UNL_KEY2: begin
                    unl_state <= (wr_unlock && wbyte == UNLOCK_KEY1)
                                 ? UNL_KEY1 : UNL_IDLE;
                end
                default: begin
                    unl_state <= UNL_IDLE;
                end
            endcase
        end else if (unl_state != UNL_IDLE) begin
            if (unl_timer == 5'(UNLOCK_WINDOW - 1)) begin
                unl_state <= UNL_IDLE;
            end else begin
                unl_timer <= unl_timer + 5'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_enable_gate <= CTRL_POR_VAL[CTRL_WEN_BIT];
        end else if (soft_reset) begin
            write_enable_gate <= 1'b0;
        end else if (wr_ctrl) begin
            write_enable_gate <= wbyte[CTRL_WEN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_start  <= CTRL_POR_VAL[CTRL_RD_BIT];
            write_start <= CTRL_POR_VAL[CTRL_WR_BIT];
        end else if (soft_reset) begin
            read_start  <= 1'b0;
            write_start <= 1'b0;
        end else begin
            read_start <= wr_ctrl && wbyte[CTRL_RD_BIT] && !arr_busy;
            if (start_ok) begin
                write_start <= 1'b1;
            end else if (arr_done) begin
                write_start <= 1'b0;
            end
        end
    end

    // abort flag on reset during write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_abort_flag <= CTRL_POR_VAL[CTRL_ABORT_BIT];
        end else if (soft_reset && arr_busy) begin
            write_abort_flag <= 1'b1;
        end else if (wr_ctrl) begin
            write_abort_flag <= wbyte[CTRL_ABORT_BIT];
        end
    end

    // ============================================================
    // Data and address registers
    // ============================================================
    // kept over non-power-on resets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eeprom_address_reg <= 8'h00;
        end else if (wr_addr && !soft_reset) begin
            eeprom_address_reg <= wbyte;
        end
    end

    // read data lands the next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eeprom_data_reg <= 8'h00;
        end else if (soft_reset) begin
            eeprom_data_reg <= eeprom_data_reg;
        end else if (read_start) begin
            eeprom_data_reg <= arr_rdata;
        end else if (wr_data) begin
            eeprom_data_reg <= wbyte;
        end
    end

    eewg_array #(
        .DEPTH     (EE_DEPTH),
        .AW        (EE_AW),
        .WR_CYCLES (WR_CNT)
    ) u_array (
        .hclk    (hclk),
        .hresetn (hresetn),
        .abort   (soft_reset),
        .start   (arr_start),
        .addr    (eeprom_address_reg[EE_AW-1:0]),
        .wdata   (eeprom_data_reg),
        .rdata   (arr_rdata),
        .busy    (arr_busy),
        .done    (arr_done)
    );

    // ============================================================
    // Interrupt status, clear and enable
    // ============================================================
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] irq_set;

    assign irq_set = {soft_reset & arr_busy, arr_done};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= irq_set |
                        (irq_stat & ~(wr_irq_clr ? hwdata[IRQ_W-1:0] : '0));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en <= '0;
        end else if (wr_irq_en) begin
            irq_en <= hwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat & irq_en);

    // ============================================================
    // Read mux
    // ============================================================
    always_comb begin
        hrdata = 32'h0000_0000;
        if (dp_read) begin
            case (dp_addr)
                ADDR_W'(DATA_IDX):     hrdata[7:0] = eeprom_data_reg;
                ADDR_W'(ADDR_IDX):     hrdata[7:0] = eeprom_address_reg;
                ADDR_W'(CTRL_IDX):     hrdata[3:0] = {write_abort_flag,
                                           write_enable_gate, write_start,
                                           read_start};
                ADDR_W'(IRQ_STAT_IDX): hrdata[IRQ_W-1:0] = irq_stat;
                ADDR_W'(IRQ_EN_IDX):   hrdata[IRQ_W-1:0] = irq_en;
                default:               hrdata = 32'h0000_0000;
            endcase
        end
    end

endmodule : eewg_top

// *** include/eewg_pkg.sv ***
// Shared constants for the data EEPROM write guard
package eewg_pkg;

    // ============================================================
    // Register indices and index width
    // ============================================================
    localparam logic [7:0]  DATA_IDX      = 8'h9a;
    localparam logic [7:0]  ADDR_IDX      = 8'h9b;
    localparam logic [7:0]  CTRL_IDX      = 8'h9c;
    localparam logic [7:0]  UNLOCK_IDX    = 8'h9d;
    localparam logic [7:0]  IRQ_STAT_IDX  = 8'ha0;
    localparam logic [7:0]  IRQ_CLR_IDX   = 8'ha1;
    localparam logic [7:0]  IRQ_EN_IDX    = 8'ha2;
    localparam int          ADDR_W        = 10;

    // ============================================================
    // Control register fields
    // ============================================================
    localparam int          CTRL_RD_BIT    = 0;
    localparam int          CTRL_WR_BIT    = 1;
    localparam int          CTRL_WEN_BIT   = 2;
    localparam int          CTRL_ABORT_BIT = 3;
    localparam logic [3:0]  CTRL_POR_VAL   = 4'h0;

    // ============================================================
    // Interrupt status fields
    // ============================================================
    localparam int          IRQ_DONE_BIT  = 0;
    localparam int          IRQ_ABORT_BIT = 1;
    localparam int          IRQ_W         = 2;

    // ============================================================
    // Unlock sequence
    // ============================================================
    localparam logic [7:0]  UNLOCK_KEY1   = 8'h55;
    localparam logic [7:0]  UNLOCK_KEY2   = 8'haa;
    localparam int          UNLOCK_WINDOW = 16;

    // ============================================================
    // Timing
    // ============================================================
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          POWERUP_DELAY_TIMER_TIME_MS    = 72;
    localparam int          POWERUP_DELAY_TIMER_CYCLES     =
        (POWERUP_DELAY_TIMER_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          WRITE_TIME_NS   = 4000;
    localparam int          WRITE_CYCLES    =
        WRITE_TIME_NS / CLK_PERIOD_NS;

    // ============================================================
    // Array geometry
    // ============================================================
    localparam int          EE_DEPTH  = 128;
    localparam int          EE_AW     = 7;

    typedef enum logic [1:0] {
        UNL_IDLE,
        UNL_KEY1,
        UNL_KEY2
    } eewg_unl_t;

endpackage : eewg_pkg

// *** hdl/eewg_array.sv ***
// Data EEPROM storage array with timed byte write
`timescale 1ns/1ps
module eewg_array
    import eewg_pkg::*;
#(
    parameter int DEPTH     = EE_DEPTH,
    parameter int AW        = EE_AW,
    parameter int WR_CYCLES = WRITE_CYCLES
) (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           abort,
    input  wire logic           start,
    input  wire logic [AW-1:0]  addr,
    input  wire logic [7:0]     wdata,
    output logic      [7:0]     rdata,
    output logic                busy,
    output logic                done
);
    import eewg_pkg::*;

    logic [7:0]     mem [DEPTH];
    logic [15:0]    count;
    logic [AW-1:0]  pend_addr;
    logic [7:0]     pend_data;

    // ============================================================
    // Write timer, data lands only at the end of the cycle
    // ============================================================
    // internal write timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy  <= 1'b0;
            count <= 16'h0000;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start && !busy) begin
                busy  <= 1'b1;
                count <= 16'(WR_CYCLES - 1);
            end else if (busy) begin
                if (count == 16'h0000) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge hclk) begin
        rdata <= mem[addr];
        if (start && !busy) begin
            pend_addr <= addr;
            pend_data <= wdata;
        end
        if (busy && !abort && count == 16'h0000) begin
            mem[pend_addr] <= pend_data;
        end
    end

endmodule : eewg_array

// *** dv/eewg_monitor.sv ***
// Bus-side assertion checker for the EEPROM write guard
`timescale 1ns/1ps
module eewg_monitor
    import eewg_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_CNT = POWERUP_DELAY_TIMER_CYCLES,
    parameter int WR_CNT   = WRITE_CYCLES
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        external_reset_pin,
    input wire logic        watchdog_timeout,
    input wire logic        code_protect,
    input wire logic        irq
);
    logic       ph_v;
    logic       ph_wr;
    logic [9:0] ph_idx;
    logic       ctrl_wr;
    logic       aa_seen;
    logic [1:0] en_sh;
    int         up_cnt;
    wire logic  rd_ph = ph_v && !ph_wr;
    wire logic  unmapped = !(ph_idx inside {10'(DATA_IDX), 10'(ADDR_IDX),
        10'(CTRL_IDX), 10'(UNLOCK_IDX), 10'(IRQ_STAT_IDX),
        10'(IRQ_CLR_IDX), 10'(IRQ_EN_IDX)});

    // ============================================================
    // Data phase and write shadows
    // ============================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_v   <= 1'b0;
            ph_wr  <= 1'b0;
            ph_idx <= 10'h000;
        end else begin
            ph_v   <= hsel && hready && htrans[1];
            ph_wr  <= hwrite;
            ph_idx <= haddr[11:2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_wr <= 1'b0;
            aa_seen <= 1'b0;
            en_sh   <= 2'h0;
        end else if (ph_v && ph_wr) begin
            if (ph_idx == 10'(CTRL_IDX))
                ctrl_wr <= 1'b1;
            if (ph_idx == 10'(UNLOCK_IDX) && hwdata[7:0] == UNLOCK_KEY2)
                aa_seen <= 1'b1;
            if (ph_idx == 10'(IRQ_EN_IDX))
                en_sh <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            up_cnt <= 0;
        else if (up_cnt < POWERUP_DELAY_TIMER_CNT)
            up_cnt <= up_cnt + 1;
    end

    // ============================================================
    // Properties
    // ============================================================
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_ready_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with error");
    chk_idle_rdata: assert property (!rd_ph |-> hrdata == 32'h0000_0000)
        else $error("read data outside read data phase");
    chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && hreadyout)
        else $error("interrupt raised right after reset");
    chk_unlock_zero: assert property (
        rd_ph && ph_idx == 10'(UNLOCK_IDX) |-> hrdata == 32'h0000_0000)
        else $error("unlock port read nonzero");
    chk_ctrl_upper: assert property (
        rd_ph && ph_idx == 10'(CTRL_IDX) |-> hrdata[31:4] == 28'h000_0000)
        else $error("control upper bits nonzero");
    chk_gate_por: assert property (
        rd_ph && ph_idx == 10'(CTRL_IDX) && !ctrl_wr |-> !hrdata[CTRL_WEN_BIT])
        else $error("gate bit set without software write");
    chk_start_unlock: assert property (
        rd_ph && ph_idx == 10'(CTRL_IDX) && hrdata[CTRL_WR_BIT] |-> aa_seen)
        else $error("write started without unlock keys");
    chk_no_early_irq: assert property (up_cnt < POWERUP_DELAY_TIMER_CNT |-> !irq &&
        !(rd_ph && ph_idx == 10'(CTRL_IDX) && hrdata[CTRL_WR_BIT]))
        else $error("write started inside power-up delay");
    chk_irq_enable: assert property (irq |-> en_sh != 2'h0)
        else $error("interrupt with no source enabled");
    chk_unmapped_zero: assert property (rd_ph && unmapped
        |=> $past(hrdata) == 32'h0000_0000)
        else $error("unmapped address read nonzero");
endmodule : eewg_monitor

bind eewg_top eewg_monitor #(.POWERUP_DELAY_TIMER_CNT(POWERUP_DELAY_TIMER_CNT), .WR_CNT(WR_CNT)) u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .external_reset_pin,
    .watchdog_timeout, .code_protect, .irq
);

// *** dv/eewg_cpu_model.sv ***
// CPU-side bus master issuing single word register accesses
`timescale 1ns/1ps
module eewg_cpu_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // One transfer; caller enters right after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wr ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // Released data lines must not echo the old value
        hwdata <= ~d;
    endtask : xfer
endmodule : eewg_cpu_model

// *** dv/eewg_tb.sv ***
// Self-checking bench for the EEPROM write guard
`timescale 1ns/1ps
module tb;
    import eewg_pkg::*;
    localparam int          PW     = 40;
    localparam int          WC     = 10;
    localparam logic [31:0] A_DATA = 32'(DATA_IDX) << 2;
    localparam logic [31:0] A_ADDR = 32'(ADDR_IDX) << 2;
    localparam logic [31:0] A_CTRL = 32'(CTRL_IDX) << 2;
    localparam logic [31:0] A_UNL  = 32'(UNLOCK_IDX) << 2;
    localparam logic [31:0] A_STAT = 32'(IRQ_STAT_IDX) << 2;
    localparam logic [31:0] A_CLR  = 32'(IRQ_CLR_IDX) << 2;
    localparam logic [31:0] A_EN   = 32'(IRQ_EN_IDX) << 2;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        ext_rst, wdt, cp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          miscompares = 0;
    int          cmp_count = 0;

    assign hready = hreadyout;
    eewg_cpu_model u_cpu (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    eewg_top #(.POWERUP_DELAY_TIMER_CNT(PW), .WR_CNT(WC)) u_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .external_reset_pin(ext_rst), .watchdog_timeout(wdt),
        .code_protect(cp), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // ============================================================
    // Access and compare tasks
    // ============================================================
    task automatic chk_val(input string n, input logic [31:0] e,
                           input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk_val

    task automatic chk_irq(input logic e);
        @(negedge hclk);
        cmp_count++;
        if (irq !== e) begin
            miscompares++;
            $display("BAD irq expected %b seen %b", e, irq);
        end
        @(posedge hclk);
    endtask : chk_irq

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_cpu.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string n, input logic [31:0] a,
                          input logic [31:0] e);
        logic [31:0] q;
        u_cpu.xfer(1'b0, a, 32'h0000_0000, q);
        chk_val(n, e, q);
    endtask : rd_chk

    // Start sequence, optionally without gate or with a stray write
    task automatic ee_start(input logic gate, input logic brk);
        wr(A_CTRL, gate ? 32'h0000_0004 : 32'h0000_0000);
        wr(A_UNL, {24'h00_0000, UNLOCK_KEY1});
        if (brk)
            wr(A_DATA, 32'h0000_00e1);
        wr(A_UNL, {24'h00_0000, UNLOCK_KEY2});
        wr(A_CTRL, gate ? 32'h0000_0006 : 32'h0000_0002);
    endtask : ee_start

    task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
        wr(A_ADDR, {24'h00_0000, a});
        wr(A_DATA, {24'h00_0000, d});
        ee_start(1'b1, 1'b0);
    endtask : ee_write

    task automatic wait_wr();
        logic [31:0] q;
        int          n;
        n = 0;
        do begin
            u_cpu.xfer(1'b0, A_CTRL, 32'h0000_0000, q);
            n++;
        end while (q[CTRL_WR_BIT] === 1'b1 && n < 100);
        chk_val("wr_done", 32'h0000_0000, 32'(q[CTRL_WR_BIT]));
    endtask : wait_wr

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5000) @(posedge hclk);
        miscompares++;
        tally_and_finish();
    end

    // ============================================================
    // Test sequence
    // ============================================================
    initial begin
        hresetn = 1'b0;
        ext_rst = 1'b0;
        wdt     = 1'b0;
        cp      = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("ctrl", A_CTRL, 32'h0000_0000);
        rd_chk("data", A_DATA, 32'h0000_0000);
        rd_chk("unlock", A_UNL, 32'h0000_0000);
        rd_chk("stat", A_STAT, 32'h0000_0000);
        rd_chk("unmapped", 32'h0000_0300, 32'h0000_0000);
        ee_write(8'h01, 8'h5a);
        rd_chk("ctrl", A_CTRL, 32'h0000_0004);
        repeat (PW + WC) @(posedge hclk);
        rd_chk("stat", A_STAT, 32'h0000_0000);
        ee_start(1'b0, 1'b0);
        rd_chk("ctrl", A_CTRL, 32'h0000_0000);
        ee_start(1'b1, 1'b1);
        rd_chk("ctrl", A_CTRL, 32'h0000_0004);
        repeat (WC + 4) @(posedge hclk);
        rd_chk("stat", A_STAT, 32'h0000_0000);
        cp <= 1'b1;
        ee_write(8'h05, 8'h3c);
        rd_chk("ctrl", A_CTRL, 32'h0000_0006);
        wr(A_CTRL, 32'h0000_0000);
        rd_chk("ctrl", A_CTRL, 32'h0000_0002);
        wait_wr();
        rd_chk("ctrl", A_CTRL, 32'h0000_0000);
        rd_chk("stat", A_STAT, 32'h0000_0001);
        chk_irq(1'b0);
        wr(A_EN, 32'h0000_0001);
        chk_irq(1'b1);
        wr(A_CLR, 32'h0000_0001);
        chk_irq(1'b0);
        wr(A_DATA, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0001);
        rd_chk("data", A_DATA, 32'h0000_003c);
        rd_chk("ctrl", A_CTRL, 32'h0000_0000);
        wr(A_EN, 32'h0000_0003);
        rd_chk("en", A_EN, 32'h0000_0003);
        for (int s = 0; s < 2; s++) begin
            ee_write(8'h06, 8'h77);
            ext_rst <= (s == 0);
            wdt     <= (s == 1);
            repeat (4) @(posedge hclk);
            ext_rst <= 1'b0;
            wdt     <= 1'b0;
            repeat (4) @(posedge hclk);
            rd_chk("ctrl", A_CTRL, 32'h0000_0008);
            rd_chk("stat", A_STAT, 32'h0000_0002);
            rd_chk("data", A_DATA, 32'h0000_0077);
            rd_chk("addr", A_ADDR, 32'h0000_0006);
            chk_irq(1'b1);
            wr(A_CLR, 32'h0000_0003);
            wr(A_CTRL, 32'h0000_0000);
        end
        tally_and_finish();
    end
endmodule : tb
